/* verilog/etl_top.sv */
/*
 * Elapsed word-time counter, dead-man supervisor, hardware tape loader
 * and buffer channel decode.
 * Assumes word_time is a one-cycle strobe per processor word time and
 * that the tape reader answers each advance with one character.
 */
// How it works
// - Program presets the word-time counter and can always read it.
// - Counter drops by one on each word time.
// - Reaching zero pulses the periodic service interrupt.
// - Without a reload, counting continues below zero.
// - Reaching the hardware load value starts a fault-restart load.
// - Read value is the preset less the word times since the last program write.
// - Loader skips to the begin marker, then writes memory from tape.
// - End marker stops loading and hands control to the program.
// - Load starts from panel button, dead-man expiry or program.
// - Program reads tape continuously at 300 cps or stepped to 50 cps.
// - Five to eight level tape accepted, eight being normal.
// - Tape reader is always buffer channel zero.
// - Channel register decodes to a one-of-128 select.
// - Counter is 14 bits and program accessible.
`timescale 1ns/1ns
module etl_top import etl_pkg::*; #(
    parameter int unsigned CONT_GAP = CONT_GAP_CYC,
    parameter int unsigned STEP_GAP = STEP_GAP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Processor timing
    input wire logic word_time,
    // Elapsed counter program access
    input wire logic q_write,
    input wire logic [13:0] q_write_data,
    output logic [13:0] q_read_data,
    output logic service_irq,
    // Load start sources
    input wire logic panel_load_button,
    input wire logic prog_load_start,
    // Channel selection
    input wire logic [6:0] chan_reg,
    output logic [127:0] chan_select,
    output logic tape_selected,
    // Program tape control
    input wire logic tape_cont_run,
    input wire logic tape_step,
    input wire logic [1:0] tape_levels,
    output logic prog_char_valid,
    output logic [7:0] prog_char,
    input wire logic prog_char_ready,
    // Tape reader
    output logic reader_advance,
    input wire logic reader_char_valid,
    input wire logic [7:0] reader_char,
    output logic reader_char_ready,
    // Memory write and control hand-over
    output logic mem_write,
    output logic [14:0] mem_addr,
    output logic [17:0] mem_wdata,
    output logic load_busy,
    output logic ctrl_transfer,
    output logic [14:0] ctrl_target
);

    // ------------------------------------------------------------
    // Elapsed word-time counter
    // ------------------------------------------------------------
    logic [13:0] q_q;
    logic deadman_armed_q;
    logic deadman_fire;
    logic service_irq_q;

    assign q_read_data = q_q;
    assign service_irq = service_irq_q;
    assign deadman_fire = deadman_armed_q && word_time && !q_write
                          && (q_q - 14'h0001 == Q_HW_LOAD_VALUE);

    // A program write wins over the word-time step in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_q <= Q_RESET;
        end else if (q_write) begin
            q_q <= q_write_data;
        end else if (word_time) begin
            q_q <= q_q - 14'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            service_irq_q <= 1'b0;
        end else begin
            service_irq_q <= word_time && !q_write
                             && (q_q == 14'h0001);
        end
    end

    // Armed from the zero crossing until a reload or the forced load
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            deadman_armed_q <= 1'b0;
        end else if (q_write) begin
            deadman_armed_q <= 1'b0;
        end else if (word_time && q_q == 14'h0001) begin
            deadman_armed_q <= 1'b1;
        end else if (deadman_fire) begin
            deadman_armed_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Channel decode
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chan_select <= 128'h0;
        end else begin
            chan_select <= 128'h1 << chan_reg;
        end
    end

    assign tape_selected = chan_select[TAPE_CHANNEL];

    // ------------------------------------------------------------
    // Character buffer between reader and consumers
    // ------------------------------------------------------------
    logic buf_valid;
    logic [7:0] buf_raw;
    logic [7:0] buf_char;
    logic buf_ready;
    etl_load_state_type ld_state_q;

    etl_char_buf u_buf (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(reader_char_valid),
        .in_data(reader_char),
        .in_ready(reader_char_ready),
        .out_valid(buf_valid),
        .out_data(buf_raw),
        .out_ready(buf_ready)
    );

    assign buf_char = etl_level_mask(tape_levels, buf_raw);
    assign load_busy = (ld_state_q != LD_IDLE);
    // The loader owns the reader while busy; the program sees nothing
    assign buf_ready = load_busy ? 1'b1 : prog_char_ready;
    assign prog_char_valid = buf_valid && !load_busy;
    assign prog_char = buf_char;

    // ------------------------------------------------------------
    // Reader pacing
    // ------------------------------------------------------------
    logic [21:0] gap_q;
    logic step_pend_q;
    logic adv_q;
    logic want_char;

    assign reader_advance = adv_q;
    assign want_char = load_busy || tape_cont_run || step_pend_q;

    // Advance only with room in the buffer, so a stall never drops a char
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            gap_q <= 22'h0;
            adv_q <= 1'b0;
        end else begin
            adv_q <= 1'b0;
            if (gap_q != 22'h0) begin
                gap_q <= gap_q - 22'h1;
            end else if (want_char && reader_char_ready) begin
                adv_q <= 1'b1;
                gap_q <= (load_busy || tape_cont_run)
                         ? GAP_W'(CONT_GAP - 1) : GAP_W'(STEP_GAP - 1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_pend_q <= 1'b0;
        end else if (tape_step) begin
            step_pend_q <= 1'b1;
        end else if (adv_q) begin
            step_pend_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Hardware loader
    // ------------------------------------------------------------
    logic load_start;
    logic take;
    logic [1:0] digit_q;
    logic [17:0] acc_q;
    logic [17:0] acc_next;
    logic [14:0] start_addr_q;

    assign load_start = panel_load_button || prog_load_start || deadman_fire;
    assign take = buf_valid && load_busy;
    assign acc_next = {acc_q[11:0], buf_char[5:0]};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ld_state_q <= LD_IDLE;
            digit_q <= 2'h0;
            acc_q <= 18'h0;
            start_addr_q <= 15'h0;
            mem_addr <= 15'h0;
        end else begin
            unique case (ld_state_q)
                LD_IDLE: begin
                    if (load_start) begin
                        ld_state_q <= LD_SEEK;
                    end
                end
                LD_SEEK: begin
                    if (take && buf_char == BEGIN_LOAD_CHAR) begin
                        ld_state_q <= LD_ADDR;
                        digit_q <= 2'h0;
                    end
                end
                LD_ADDR, LD_DATA: begin
                    if (take && buf_char == END_LOAD_CHAR) begin
                        ld_state_q <= LD_IDLE;
                    end else if (take) begin
                        acc_q <= acc_next;
                        if (digit_q == 2'(DIGITS_PER_WORD - 1)) begin
                            digit_q <= 2'h0;
                            if (ld_state_q == LD_ADDR) begin
                                start_addr_q <= acc_next[14:0];
                                mem_addr <= acc_next[14:0];
                                ld_state_q <= LD_DATA;
                            end
                        end else begin
                            digit_q <= digit_q + 2'h1;
                        end
                    end
                    if (mem_write) begin
                        mem_addr <= mem_addr + 15'h1;
                    end
                end
            endcase
        end
    end

    // Each third data digit completes one memory word
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_write <= 1'b0;
            mem_wdata <= 18'h0;
        end else begin
            mem_write <= take && ld_state_q == LD_DATA
                         && buf_char != END_LOAD_CHAR
                         && digit_q == 2'(DIGITS_PER_WORD - 1);
            mem_wdata <= acc_next;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_transfer <= 1'b0;
            ctrl_target <= 15'h0;
        end else begin
            ctrl_transfer <= take && buf_char == END_LOAD_CHAR
                             && ld_state_q != LD_SEEK;
            ctrl_target <= start_addr_q;
        end
    end

endmodule : etl_top

/* verilog/etl_pkg.sv */
/*
 * Shared constants for the elapsed word-time timer and tape loader.
 * Assumes a 100 MHz system clock; all figures below are named once here.
 */
package etl_pkg;

    // ------------------------------------------------------------
    // Clock and tape reader rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned CONT_RATE_CPS = 300;
    localparam int unsigned STEP_RATE_CPS = 50;
    // Least spacing between characters rounds up to whole cycles
    localparam int unsigned CONT_GAP_CYC =
        (CLK_HZ + CONT_RATE_CPS - 1) / CONT_RATE_CPS;
    localparam int unsigned STEP_GAP_CYC =
        (CLK_HZ + STEP_RATE_CPS - 1) / STEP_RATE_CPS;
    localparam int GAP_W = 22;

    // ------------------------------------------------------------
    // Elapsed word-time counter
    // ------------------------------------------------------------
    localparam int Q_W = 14;
    localparam logic [13:0] Q_RESET = 14'h0000;
    // Count reached after running past zero that forces a load
    localparam logic [13:0] Q_HW_LOAD_VALUE = 14'h3FC0;

    // ------------------------------------------------------------
    // Channel selector and memory
    // ------------------------------------------------------------
    localparam int CHAN_W = 7;
    localparam int CHAN_N = 128;
    localparam logic [6:0] TAPE_CHANNEL = 7'h00;
    localparam int ADDR_W = 15;
    localparam int WORD_W = 18;
    localparam int CHAR_W = 8;
    localparam int DIGIT_W = 6;
    localparam int DIGITS_PER_WORD = 3;

    // ------------------------------------------------------------
    // Tape characters and tape widths
    // ------------------------------------------------------------
    localparam logic [7:0] BEGIN_LOAD_CHAR = 8'hF0;
    localparam logic [7:0] END_LOAD_CHAR = 8'hF1;
    localparam logic [1:0] LEVELS_5 = 2'h0;
    localparam logic [1:0] LEVELS_6 = 2'h1;
    localparam logic [1:0] LEVELS_7 = 2'h2;
    localparam logic [1:0] LEVELS_8 = 2'h3;

    typedef enum logic [1:0] {
        LD_IDLE,
        LD_SEEK,
        LD_ADDR,
        LD_DATA
    } etl_load_state_type;

    // Keep only the punched levels of a character
    function automatic logic [7:0] etl_level_mask(input logic [1:0] lv,
                                                  input logic [7:0] ch);
        unique case (lv)
            LEVELS_5: etl_level_mask = ch & 8'h1F;
            LEVELS_6: etl_level_mask = ch & 8'h3F;
            LEVELS_7: etl_level_mask = ch & 8'h7F;
            LEVELS_8: etl_level_mask = ch;
        endcase
    endfunction : etl_level_mask

endpackage : etl_pkg

/* verilog/etl_char_buf.sv */
/*
 * Two-entry character buffer with valid/ready on both sides.
 * Assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ns
module etl_char_buf import etl_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);

    logic [7:0] slot0_q;
    logic [7:0] slot1_q;
    logic [1:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data = slot0_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= 2'h0;
        end else begin
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Head always sits in slot0; the second word shifts down on a pop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slot0_q <= 8'h00;
            slot1_q <= 8'h00;
        end else begin
            if (pop) begin
                slot0_q <= (count_q == 2'h2) ? slot1_q : in_data;
                if (push && count_q == 2'h2) begin
                    slot1_q <= in_data;
                end
            end else if (push) begin
                if (count_q == 2'h0) begin
                    slot0_q <= in_data;
                end else begin
                    slot1_q <= in_data;
                end
            end
        end
    end

endmodule : etl_char_buf

/* dv/etl_top_properties.sv */
/* Port assertions for etl_top: counter, dead-man start, decode, loader.
   Assumes binding into etl_top, one clock, rst_n synchronous low. */
`timescale 1ns/1ns
module etl_top_properties import etl_pkg::*; #(
    parameter int unsigned CONT_GAP = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Counter
    input wire logic word_time,
    input wire logic q_write,
    input wire logic [13:0] q_write_data,
    input wire logic [13:0] q_read_data,
    input wire logic service_irq,
    // Loader
    input wire logic panel_load_button,
    input wire logic prog_load_start,
    input wire logic load_busy,
    input wire logic ctrl_transfer,
    input wire logic mem_write,
    input wire logic reader_advance,
    input wire logic prog_char_valid,
    // Channels
    input wire logic [6:0] chan_reg,
    input wire logic [127:0] chan_select,
    input wire logic tape_selected
);
    logic irq_go, dm_go, start_go, armed_q;
    logic [15:0] gap_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    assign irq_go = word_time && !q_write && q_read_data == 14'h0001;
    // Armed by the zero pulse; any program write disarms it
    assign dm_go = armed_q && word_time && !q_write
        && q_read_data == Q_HW_LOAD_VALUE + 14'h0001;
    assign start_go = panel_load_button || prog_load_start || dm_go;

    always_ff @(posedge clk) begin
        if (!rst_n || q_write)
            armed_q <= 1'h0;
        else if (service_irq)
            armed_q <= 1'h1;
        // A forced load uses up the arm, as in the design
        else if (dm_go)
            armed_q <= 1'h0;
    end

    // Saturates so a long idle spell never wraps into a false short gap
    always_ff @(posedge clk) begin
        if (!rst_n)
            gap_q <= 16'hFFFF;
        else if (reader_advance)
            gap_q <= 16'h0001;
        else if (gap_q != 16'hFFFF)
            gap_q <= gap_q + 16'h0001;
    end

    property p_q_load;
        q_write |=> q_read_data == $past(q_write_data);
    endproperty
    a_q_load: assert property (p_q_load)
        else $error("counter missed a write");
    property p_q_dec;
        word_time && !q_write |=> q_read_data == $past(q_read_data) - 14'h1;
    endproperty
    a_q_dec: assert property (p_q_dec)
        else $error("counter did not step down by one");
    property p_irq;
        rst_n |=> service_irq == $past(irq_go);
    endproperty
    a_irq: assert property (p_irq)
        else $error("zero pulse wrong");
    property p_dm;
        dm_go |=> load_busy;
    endproperty
    a_dm: assert property (p_dm)
        else $error("dead-man load did not start");
    property p_start;
        $rose(load_busy) |-> $past(start_go);
    endproperty
    a_start: assert property (p_start)
        else $error("load started without a cause");
    property p_chan;
        rst_n |=> chan_select == 128'h1 << $past(chan_reg);
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel select not one-hot of register");
    property p_tsel;
        rst_n |=> tape_selected == ($past(chan_reg) == TAPE_CHANNEL);
    endproperty
    a_tsel: assert property (p_tsel)
        else $error("tape select wrong");
    property p_gap;
        reader_advance |-> 32'(gap_q) >= CONT_GAP;
    endproperty
    a_gap: assert property (p_gap)
        else $error("reader advanced too fast");
    property p_xfer;
        ctrl_transfer == $fell(load_busy);
    endproperty
    a_xfer: assert property (p_xfer)
        else $error("hand-over not tied to end of load");
    property p_busy;
        (load_busy |-> !prog_char_valid) and (mem_write |-> load_busy);
    endproperty
    a_busy: assert property (p_busy)
        else $error("loader and program stream overlap");
endmodule : etl_top_properties

/* dv/etl_tape_model.sv */
/* Paper tape reader model: one character per advance, prompt or slow.
   Assumes the bench fills the tape array before starting a load. */
`timescale 1ns/1ns
module etl_tape_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Requests and pacing
    input wire logic reader_advance,
    input wire logic [7:0] slow_cycles,
    // Character handshake
    output logic reader_char_valid,
    output logic [7:0] reader_char,
    input wire logic reader_char_ready
);
    logic [7:0] tape [256];
    logic [7:0] pos_q, wait_q;
    logic [2:0] pend_q;
    logic show;

    initial begin
        for (int i = 0; i < 256; i++)
            tape[i] = 8'(i * 37 + 90);
    end

    assign show = !reader_char_valid && pend_q != 3'h0 && wait_q == 8'h00;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reader_char_valid <= 1'h0;
            reader_char <= 8'hA5;
            pos_q <= 8'h00;
            pend_q <= 3'h0;
            wait_q <= 8'h00;
        end else begin
            pend_q <= pend_q + {2'h0, reader_advance} - {2'h0, show};
            if (reader_advance && pend_q == 3'h0)
                wait_q <= slow_cycles;
            else if (wait_q != 8'h00)
                wait_q <= wait_q - 8'h01;
            if (show) begin
                reader_char_valid <= 1'h1;
                reader_char <= tape[pos_q];
                pos_q <= pos_q + 8'h01;
            end else if (reader_char_valid && reader_char_ready) begin
                reader_char_valid <= 1'h0;
                // Released line must not keep showing the old frame
                reader_char <= ~reader_char;
            end
        end
    end
endmodule : etl_tape_model

/* dv/tb_etl_top.sv */
/* Bench for etl_top: counter, decode, program tape and three loads.
   Assumes the package, design and dv files are compiled first. */
`timescale 1ns/1ns
module tb_etl_top import etl_pkg::*; ;
    // Short gaps keep tape pacing visible in a short run
    localparam int unsigned CG = 8;
    localparam int unsigned SG = 20;
    logic clk, rst_n, word_time, q_write, service_irq, tape_selected;
    logic panel_load_button, prog_load_start, load_busy, ctrl_transfer;
    logic tape_cont_run, tape_step, prog_char_valid, prog_char_ready;
    logic reader_advance, reader_char_valid, reader_char_ready, mem_write;
    logic [1:0] tape_levels;
    logic [6:0] chan_reg;
    logic [7:0] prog_char, reader_char, slow_cycles;
    logic [13:0] q_write_data, q_read_data;
    logic [14:0] mem_addr, ctrl_target;
    logic [17:0] mem_wdata;
    logic [127:0] chan_select;
    logic [14:0] wa[$];
    logic [17:0] wd[$];
    int fails, n_tests, tp;

    etl_top #(.CONT_GAP(CG), .STEP_GAP(SG)) uut (.*);
    etl_tape_model tape_mdl (.*);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mem_write === 1'h1) begin
            wa.push_back(mem_addr);
            wd.push_back(mem_wdata);
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [127:0] seen,
                       input logic [127:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic wait_hi(ref logic s, input int lim);
        for (int i = 0; i < lim && s !== 1'h1; i++)
            @(posedge clk);
        if (s !== 1'h1) begin
            chk("wait", s, 1'h1);
            finish_test();
        end
    endtask : wait_hi

    task automatic wt(input int n);
        repeat (n) begin
            @(posedge clk);
            word_time <= 1'h1;
        end
        @(posedge clk);
        word_time <= 1'h0;
        #1;
    endtask : wt

    task automatic qw(input logic [13:0] v);
        @(posedge clk);
        q_write <= 1'h1;
        q_write_data <= v;
        @(posedge clk);
        q_write <= 1'h0;
        #1;
    endtask : qw

    task automatic put(input logic [7:0] ch);
        tape_mdl.tape[tp] = ch;
        tp++;
    endtask : put

    task automatic put3(input logic [17:0] w);
        put({2'h0, w[17:12]});
        put({2'h0, w[11:6]});
        put({2'h0, w[5:0]});
    endtask : put3

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_counter();
        qw(14'h3FFF);
        chk("q_full", q_read_data, 14'h3FFF);
        qw(14'h0064);
        wt(7);
        chk("q_used", q_read_data, 14'h005D);
        qw(14'h0003);
        wt(2);
        chk("irq_early", service_irq, 1'h0);
        wt(1);
        chk("q_zero", q_read_data, 14'h0000);
        chk("irq", service_irq, 1'h1);
        @(posedge clk);
        #1;
        chk("irq_once", service_irq, 1'h0);
    endtask : t_counter

    task automatic t_chan();
        for (int c = 0; c < 128; c++) begin
            @(posedge clk);
            chan_reg <= 7'(c);
            @(posedge clk);
            #1;
            chk("chan_sel", chan_select, 128'h1 << c);
            chk("tape_sel", tape_selected, c == 0);
        end
    endtask : t_chan

    task automatic t_tape();
        int k, n;
        logic [7:0] msk;
        k = 0;
        for (int lv = 0; lv < 4; lv++) begin
            @(posedge clk);
            tape_levels <= 2'(lv);
            tape_step <= 1'h1;
            @(posedge clk);
            tape_step <= 1'h0;
            wait_hi(prog_char_valid, 4 * SG);
            msk = 8'hFF >> (3 - lv);
            chk("step", prog_char, tape_mdl.tape[k] & msk);
            k++;
            prog_char_ready <= 1'h1;
            @(posedge clk);
            prog_char_ready <= 1'h0;
        end
        tape_levels <= LEVELS_8;
        tape_cont_run <= 1'h1;
        repeat (10 * CG) @(posedge clk);
        #1;
        chk("buf_full", reader_char_ready, 1'h0);
        @(posedge clk);
        tape_cont_run <= 1'h0;
        prog_char_ready <= 1'h1;
        n = 0;
        repeat (4 * CG) begin
            @(posedge clk);
            if (prog_char_valid === 1'h1) begin
                chk("cont", prog_char, tape_mdl.tape[k]);
                k++;
                n++;
            end
        end
        prog_char_ready <= 1'h0;
        chk("buf_depth", n, 2);
    endtask : t_tape

    task automatic t_load(input int src, input logic [14:0] a);
        tp = int'(tape_mdl.pos_q);
        wa.delete();
        wd.delete();
        put(END_LOAD_CHAR);
        put(8'h2C);
        put(BEGIN_LOAD_CHAR);
        put3({3'h0, a});
        put3({a, 3'h5});
        put3(~{3'h0, a});
        put(8'h15);
        put(END_LOAD_CHAR);
        put(8'h2C);
        put(8'h2C);
        slow_cycles <= 8'(src * 3);
        if (src == 2) begin
            qw(14'h0001);
            wt(64);
            // Reload above the trip value: a stale arm would fire here
            qw(14'h3FC4);
            wt(5);
            chk("cancel", load_busy, 1'h0);
            qw(14'h0001);
            wt(64);
            chk("past_zero", q_read_data, 14'h3FC1);
            chk("no_load", load_busy, 1'h0);
            wt(1);
        end else begin
            @(posedge clk);
            panel_load_button <= src == 0;
            prog_load_start <= src == 1;
            @(posedge clk);
            panel_load_button <= 1'h0;
            prog_load_start <= 1'h0;
            #1;
        end
        chk("busy", load_busy, 1'h1);
        wait_hi(ctrl_transfer, 3000);
        chk("target", ctrl_target, a);
        chk("idle", load_busy, 1'h0);
        chk("writes", wa.size(), 2);
        chk("addr0", wa[0], a);
        chk("addr1", wa[1], a + 15'h1);
        chk("data0", wd[0], {a, 3'h5});
        // Cast keeps the inversion to the 18 bits of a memory word
        chk("data1", wd[1], 18'(~{3'h0, a}));
    endtask : t_load

    initial begin
        {rst_n, word_time, q_write, panel_load_button} = 4'h0;
        {prog_load_start, tape_cont_run, tape_step, prog_char_ready} = 4'h0;
        q_write_data = 14'h0000;
        chan_reg = 7'h00;
        tape_levels = LEVELS_8;
        slow_cycles = 8'h00;
        fails = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'h1;
        t_counter();
        t_chan();
        t_tape();
        t_load(2, 15'h1234);
        t_load(0, 15'h7FFE);
        t_load(1, 15'h0040);
        finish_test();
    end
endmodule : tb_etl_top

bind etl_top etl_top_properties #(.CONT_GAP(CONT_GAP)) u_props (.*);
